// ==== rtl/dlc_loop_filter_top.sv ====
// Loop filter control of the internal clock generator with its
// register port, interrupt logic and digital oscillator instance.
// Assumes BASE_TICK pulses once per base clock period, synchronous to CLOCK.
//
// Overview of operation
// [R01] Period follows an 8-bit stage code and 4-bit divider code from the filter.
// [R02] Divider divides by two to the code; codes ten to fifteen act as nine.
// [R03] Each divider code increment doubles the period, each decrement halves it.
// [R04] Divider code moves only by carry or borrow of stage code arithmetic.
// [R05] Upper three stage bits choose 17 to 31 stage delays in steps of two.
// [R06] Lower five bits k stretch the ring by two delays k of 32 cycles.
// [R07] Upper bits 111 alternate 31 delays with 17 doubled, giving 34.
// [R08] Above 15 percent error each correction moves the stage code by bit 5.
// [R09] Eight coarse corrections double or halve the internal clock period.
// [R10] Smallest correction is one least significant stage code step.
// [R11] Each correction spans four base clock periods.
// [R12] Between 15 and 5 percent, medium corrections reach 5 percent within eight.
// [R13] Below 5 percent error the internal stable flag is set.
// [R14] Target internal clock is multiplier times the 307.2 kHz base clock.
// [R15] Settling restarts after reset, multiplier or trim change, and re-enable.
// [R16] Software turns the clock monitor off before changing the multiplier.
// [R17] Monitor enable is refused until the stable flag is set again.
// [R18] Software checks the monitor flag, then follows the frequency change flow.
// [R19] Medium corrections add or subtract the stage code bit 3 weight.
//
// Our own choices: the address map and strobed register access.
`include "dlc_params.svh"
module dlc_loop_filter_top
  import dlc_pkg::*;
(
  input wire logic CLOCK,                  // 40 MHz system clock
  input wire logic ARST_N,                 // Asynchronous reset, active low
  input wire logic [3:0] ADDR,             // Register word index
  input wire logic [15:0] WDATA,           // Write data
  input wire logic WR,                     // Write strobe
  input wire logic RD,                     // Read strobe
  output logic [15:0] RDATA,               // Read data, cycle after RD
  input wire logic BASE_TICK,              // One pulse per base clock period
  input wire logic STOP_REQ,               // Stop mode, oscillator halted
  input wire logic MONITOR_EVENT,          // Clock monitor saw a dead clock
  output logic INTERNAL_CLOCK_TICK,        // One pulse per internal clock period
  output logic [7:0] STAGE_CODE,           // Stage code to the oscillator
  output logic [3:0] DIVIDER_CODE,         // Divider code to the oscillator
  output logic [7:0] TRIM_CODE,            // Trim factor to the base oscillator
  output logic INTERNAL_STABLE_FLAG,       // Error under 5 percent
  output logic MONITOR_ON,                 // Clock monitor enable
  output logic IRQ                         // Interrupt, level, active high
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dlc_filter_e state;
  dlc_filter_e next_state;
  dlc_regime_e regime;
  dlc_code_t code;
  dlc_code_t next_code;
  dlc_code_t step;
  logic [12:0] sum;
  logic osc_en;
  logic [6:0] mult;
  logic [7:0] trim;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [2:0] int_events;
  logic running;
  logic running_d;
  logic restart;
  logic [1:0] base_cnt;
  logic [9:0] tick_cnt;
  logic win_end;
  logic osc_tick;
  logic [8:0] target;
  logic fast;
  logic [9:0] mag;
  logic [15:0] mag_scaled;
  logic [15:0] target_wide;
  logic fine_zone;
  logic wr_ctrl;
  logic wr_mult;
  logic wr_trim;
  logic wr_int;
  logic wr_mask;
  logic mon_request;
  logic mon_refused;
  logic stable_rise;
  logic [15:0] next_rdata;
  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign wr_ctrl = WR && (ADDR == `DLC_ADDR_CTRL);
  assign wr_mult = WR && (ADDR == `DLC_ADDR_MULT);
  assign wr_trim = WR && (ADDR == `DLC_ADDR_TRIM);
  assign wr_int = WR && (ADDR == `DLC_ADDR_INT_STATUS);
  assign wr_mask = WR && (ADDR == `DLC_ADDR_INT_MASK);
  // Monitor may only be switched on while the clock is stable
  assign mon_request = wr_ctrl && WDATA[`DLC_CTRL_MON_ON] && !MONITOR_ON;
  assign mon_refused = mon_request && !INTERNAL_STABLE_FLAG; // R17
  // Oscillator enable
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      osc_en <= `DLC_OSC_EN_RST;
    else if (wr_ctrl)
      osc_en <= WDATA[`DLC_CTRL_OSC_EN];
  end
  // Clock monitor enable, refused while unstable
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      MONITOR_ON <= 1'b0;
    else if (wr_ctrl && !WDATA[`DLC_CTRL_MON_ON])
      MONITOR_ON <= 1'b0;
    else if (mon_request && INTERNAL_STABLE_FLAG)
      MONITOR_ON <= 1'b1; // R17
  end
  // Multiplier and trim factors
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mult <= `DLC_MULT_RST;
      trim <= `DLC_TRIM_RST;
    end
    else
    begin
      if (wr_mult)
        mult <= WDATA[6:0];
      if (wr_trim)
        trim <= WDATA[7:0];
    end
  end
  assign TRIM_CODE = trim;
  // ----------------------------------------------------------------
  // Settling restart
  // ----------------------------------------------------------------
  assign running = osc_en && !STOP_REQ;
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      running_d <= 1'b0;
    else
      running_d <= running;
  end
  // Reset release, factor change or re-enable restarts settling
  assign restart = (running && !running_d) // R15
    || (wr_mult && WDATA[6:0] != mult)
    || (wr_trim && WDATA[7:0] != trim);
  // ----------------------------------------------------------------
  // Correction window of four base periods
  // ----------------------------------------------------------------
  assign win_end = running && !restart && (state != DLC_FLT_OFF)
    && BASE_TICK && (base_cnt == `DLC_WINDOW_LAST); // R11
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      base_cnt <= 2'h0;
    else if (!running || restart)
      base_cnt <= 2'h0;
    else if (BASE_TICK)
      base_cnt <= base_cnt + 2'h1; // R11
  end
  // Internal clock periods seen in the window, saturating
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      tick_cnt <= 10'h000;
    else if (!running || restart)
      tick_cnt <= 10'h000;
    else if (win_end)
      tick_cnt <= {9'h000, osc_tick};
    else if (osc_tick && tick_cnt != 10'h3ff)
      tick_cnt <= tick_cnt + 10'h001;
  end
  // ----------------------------------------------------------------
  // Error measurement and regime
  // ----------------------------------------------------------------
  always_comb
  begin
    target = {mult, 2'h0}; // R14
    fast = tick_cnt > {1'b0, target};
    mag = fast ? tick_cnt - {1'b0, target} : {1'b0, target} - tick_cnt;
    mag_scaled = {6'h00, mag} * `DLC_PCT_SCALE;
    target_wide = {7'h00, target};
    fine_zone = mag_scaled < target_wide;
    if (mag_scaled > target_wide * `DLC_PCT_COARSE)
      regime = DLC_REG_COARSE; // R08
    else if (!fine_zone)
      regime = DLC_REG_MEDIUM; // R12
    else
      regime = DLC_REG_FINE;
  end
  // Step size per regime
  always_comb
  begin
    case (regime)
      DLC_REG_COARSE: step = `DLC_STEP_COARSE; // R08 R09
      DLC_REG_MEDIUM: step = `DLC_STEP_MEDIUM; // R19
      DLC_REG_FINE: step = `DLC_STEP_FINE; // R10
      default: step = `DLC_STEP_FINE;
    endcase
  end
  // ----------------------------------------------------------------
  // Code arithmetic: divider moves only by carry or borrow
  // ----------------------------------------------------------------
  always_comb
  begin
    sum = {1'b0, code} + {1'b0, step};
    next_code = code;
    if (win_end && mag != 10'h000)
    begin
      if (fast)
        next_code = sum[12] ? `DLC_CODE_MAX : sum[11:0]; // R04
      else
        next_code = (code < step) ? `DLC_CODE_RST : code - step; // R04
    end
  end
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      code <= `DLC_CODE_RST;
    else
      code <= next_code; // R01
  end
  assign STAGE_CODE = code[7:0];
  assign DIVIDER_CODE = code[11:8];
  // ----------------------------------------------------------------
  // Filter state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      DLC_FLT_OFF:
        if (restart)
          next_state = DLC_FLT_SETTLE;
      DLC_FLT_SETTLE:
        if (!running)
          next_state = DLC_FLT_OFF;
        else if (win_end && fine_zone)
          next_state = DLC_FLT_LOCKED; // R13
      DLC_FLT_LOCKED:
        if (!running)
          next_state = DLC_FLT_OFF;
        else if (restart)
          next_state = DLC_FLT_SETTLE; // R15
      default:
        next_state = DLC_FLT_OFF;
    endcase
  end
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      state <= DLC_FLT_OFF;
    else
      state <= next_state;
  end
  assign INTERNAL_STABLE_FLAG = (state == DLC_FLT_LOCKED); // R13
  assign stable_rise = (state == DLC_FLT_SETTLE) && (next_state == DLC_FLT_LOCKED);
  // ----------------------------------------------------------------
  // Interrupt flags, set wins over write-one clear
  // ----------------------------------------------------------------
  always_comb
  begin
    int_events = 3'h0;
    int_events[`DLC_INT_STABLE] = stable_rise;
    int_events[`DLC_INT_MON_EVENT] = MONITOR_EVENT;
    int_events[`DLC_INT_REFUSED] = mon_refused;
  end
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      int_status <= 3'h0;
    else
      int_status <= (int_status & ~(wr_int ? WDATA[2:0] : 3'h0)) | int_events;
  end
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      int_mask <= 3'h0;
    else if (wr_mask)
      int_mask <= WDATA[2:0];
  end
  assign IRQ = |(int_status & int_mask);
  // ----------------------------------------------------------------
  // Register read, zero outside the answer cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 16'h0000;
    if (!RD)
      next_rdata = 16'h0000;
    else if (ADDR == `DLC_ADDR_CTRL)
      next_rdata = {14'h0000, MONITOR_ON, osc_en};
    else if (ADDR == `DLC_ADDR_MULT)
      next_rdata = {9'h000, mult};
    else if (ADDR == `DLC_ADDR_TRIM)
      next_rdata = {8'h00, trim};
    else if (ADDR == `DLC_ADDR_STATUS)
      next_rdata = {13'h0000, running, MONITOR_ON, INTERNAL_STABLE_FLAG};
    else if (ADDR == `DLC_ADDR_CODES)
      next_rdata = {4'h0, code};
    else if (ADDR == `DLC_ADDR_INT_STATUS)
      next_rdata = {13'h0000, int_status};
    else if (ADDR == `DLC_ADDR_INT_MASK)
      next_rdata = {13'h0000, int_mask};
  end
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      RDATA <= 16'h0000;
    else
      RDATA <= next_rdata;
  end
  // ----------------------------------------------------------------
  // Digital oscillator
  // ----------------------------------------------------------------
  dlc_digital_oscillator u_osc
  (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .enable(running),
    .stage_code(code[7:0]),
    .divider_code(code[11:8]),
    .clock_tick(osc_tick)
  );
  assign INTERNAL_CLOCK_TICK = osc_tick;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] base_seen;
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      base_seen <= 3'h0;
    else if (win_end || restart || !running)
      base_seen <= 3'h0;
    else if (BASE_TICK)
      base_seen <= base_seen + 3'h1;
  end
  sequence s_correct(dlc_regime_e r);
    win_end && regime == r && mag != 10'h000;
  endsequence
  chk_divider_carry_only: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R04
    !$stable(code[11:8]) |-> $past(win_end))
    else $error("divider code moved without a correction");
  chk_coarse_step: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R08
    s_correct(DLC_REG_COARSE) ##0 (fast && code < 12'hfe0)
    |=> code == $past(code) + 12'h020)
    else $error("coarse step is not bit 5");
  chk_coarse_carry: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R09
    s_correct(DLC_REG_COARSE) ##0 (fast && code[7:5] == 3'h7 && code[11:8] != 4'hf)
    |=> DIVIDER_CODE == $past(code[11:8]) + 4'h1)
    else $error("eighth coarse step did not carry");
  chk_medium_step: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R19
    s_correct(DLC_REG_MEDIUM) ##0 (!fast && code >= 12'h008)
    |=> code == $past(code) - 12'h008)
    else $error("medium step is not bit 3");
  chk_fine_step: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R10
    s_correct(DLC_REG_FINE) ##0 (fast && code != 12'hfff)
    |=> code == $past(code) + 12'h001)
    else $error("fine step is not one");
  chk_stable_set: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R13
    win_end && fine_zone && state == DLC_FLT_SETTLE ##1 running
    |-> INTERNAL_STABLE_FLAG)
    else $error("stable flag not set under 5 percent");
  chk_restart_clears: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R15
    restart && running |=> !INTERNAL_STABLE_FLAG ##1 (state != DLC_FLT_LOCKED))
    else $error("restart kept the stable flag");
  chk_monitor_refused: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R17
    mon_request && !INTERNAL_STABLE_FLAG
    |=> !MONITOR_ON && int_status[`DLC_INT_REFUSED])
    else $error("monitor enabled while unstable");
  chk_window_four: assert property (@(posedge CLOCK) disable iff (!ARST_N) // R11
    win_end |-> base_seen == 3'h3)
    else $error("window is not four base periods");
endmodule

// ==== rtl/dlc_params.svh ====
// Constants of the oscillator and loop filter control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef DLC_PARAMS_SVH
`define DLC_PARAMS_SVH
// ----------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------
`define DLC_ADDR_CTRL 4'h0
`define DLC_ADDR_MULT 4'h1
`define DLC_ADDR_TRIM 4'h2
`define DLC_ADDR_STATUS 4'h3
`define DLC_ADDR_CODES 4'h4
`define DLC_ADDR_INT_STATUS 4'h5
`define DLC_ADDR_INT_MASK 4'h6
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DLC_CTRL_OSC_EN 0
`define DLC_CTRL_MON_ON 1
`define DLC_INT_STABLE 0
`define DLC_INT_MON_EVENT 1
`define DLC_INT_REFUSED 2
`define DLC_OSC_EN_RST 1'h1
`define DLC_MULT_RST 7'h01
`define DLC_TRIM_RST 8'h80
`define DLC_CODE_RST 12'h000
`define DLC_CODE_MAX 12'hfff
// ----------------------------------------------------------------
// Oscillator structure: divider code limit, then lengths in stage delays
// ----------------------------------------------------------------
`define DLC_DIV_MAX 4'h9
`define DLC_RING_MIN 6'h11
`define DLC_FINE_EXTRA 6'h02
`define DLC_SPLIT_LEN 6'h22
// ----------------------------------------------------------------
// Loop filter timing and steps
// ----------------------------------------------------------------
`define DLC_WINDOW_LAST 2'h3
`define DLC_STEP_COARSE 12'h020
`define DLC_STEP_MEDIUM 12'h008
`define DLC_STEP_FINE 12'h001
`define DLC_PCT_SCALE 16'h0014
`define DLC_PCT_COARSE 16'h0003
`endif

// ==== rtl/dlc_pkg.sv ====
// Types shared by the oscillator and loop filter control block.
// Assumes nothing of its surroundings.
package dlc_pkg;
  // ----------------------------------------------------------------
  // Filter states and correction regimes
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    DLC_FLT_OFF = 3'b001,
    DLC_FLT_SETTLE = 3'b010,
    DLC_FLT_LOCKED = 3'b100
  } dlc_filter_e;
  typedef enum logic [2:0]
  {
    DLC_REG_FINE = 3'b001,
    DLC_REG_MEDIUM = 3'b010,
    DLC_REG_COARSE = 3'b100
  } dlc_regime_e;
  // Divider code above stage code
  typedef logic [11:0] dlc_code_t;
endpackage

// ==== rtl/dlc_digital_oscillator.sv ====
// Digital oscillator: ring length select, fine-adjust sequencer and
// binary weighted divider. One stage delay is one CLOCK period.
// Assumes stage and divider codes come from flip-flops of the filter.
`include "dlc_params.svh"
module dlc_digital_oscillator
  import dlc_pkg::*;
(
  input wire logic clock,             // System clock
  input wire logic arst_n,            // Asynchronous reset, active low
  input wire logic enable,            // Oscillator running
  input wire logic [7:0] stage_code,  // Ring length and fine adjust
  input wire logic [3:0] divider_code, // Power of two divider
  output logic clock_tick             // One pulse per output period
);
  logic [5:0] nominal;
  logic [5:0] ring_len;
  logic [5:0] fine_sum;
  logic [5:0] delay_cnt;
  logic [4:0] fine_acc;
  logic [8:0] div_cnt;
  logic [8:0] div_last;
  logic [3:0] div_eff;
  logic extend;
  logic ring_end;
  // ----------------------------------------------------------------
  // Ring length for the current ring cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    nominal = `DLC_RING_MIN + {2'h0, stage_code[7:5], 1'b0}; // R05
    fine_sum = {1'b0, fine_acc} + {1'b0, stage_code[4:0]}; // R06
    extend = fine_sum[5];
    if (!extend)
      ring_len = nominal;
    else if (stage_code[7:5] == 3'h7)
      ring_len = `DLC_SPLIT_LEN; // R07
    else
      ring_len = nominal + `DLC_FINE_EXTRA; // R06
  end
  // Codes above nine act as nine
  assign div_eff = (divider_code > `DLC_DIV_MAX) ? `DLC_DIV_MAX : divider_code; // R02
  assign div_last = 9'h1ff >> (`DLC_DIV_MAX - div_eff); // R02 R03
  assign ring_end = enable && (delay_cnt == ring_len - 6'h01);
  // Stage delay counter inside one ring cycle
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      delay_cnt <= 6'h00;
    else if (!enable || ring_end)
      delay_cnt <= 6'h00;
    else
      delay_cnt <= delay_cnt + 6'h01;
  end
  // Accumulator spreads k long cycles evenly over 32
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      fine_acc <= 5'h00;
    else if (ring_end)
      fine_acc <= fine_sum[4:0]; // R06
  end
  // Divider counts ring cycles; a shrunk code ends the count at the next ring end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      div_cnt <= 9'h000;
    else if (!enable)
      div_cnt <= 9'h000;
    else if (ring_end)
      div_cnt <= (div_cnt >= div_last) ? 9'h000 : div_cnt + 9'h001; // R02
  end
  // Registered output pulse
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      clock_tick <= 1'b0;
    else
      clock_tick <= ring_end && (div_cnt >= div_last);
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [14:0] period_cnt;
  logic codes_held;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      period_cnt <= 15'h0000;
      codes_held <= 1'b0;
    end
    else
    begin
      period_cnt <= clock_tick ? 15'h0001 : period_cnt + 15'h0001;
      if (!enable || !$stable(stage_code) || !$stable(divider_code))
        codes_held <= 1'b0;
      else if (clock_tick)
        codes_held <= 1'b1;
    end
  end
  chk_ring_nominal: assert property (@(posedge clock) disable iff (!arst_n) // R05
    clock_tick && codes_held && div_eff == 4'h0 && stage_code[4:0] == 5'h00
    |-> period_cnt == {9'h000, nominal})
    else $error("nominal ring period wrong");
  chk_divide_ratio: assert property (@(posedge clock) disable iff (!arst_n) // R02
    clock_tick && codes_held && stage_code[4:0] == 5'h00
    |-> period_cnt == ({9'h000, nominal} << div_eff))
    else $error("divided period wrong");
  chk_fine_zero: assert property (@(posedge clock) disable iff (!arst_n) // R06
    stage_code[4:0] == 5'h00 |-> ring_len == nominal)
    else $error("zero fine code stretched the ring");
  chk_split_length: assert property (@(posedge clock) disable iff (!arst_n) // R07
    stage_code[7:5] == 3'h7 && extend |-> ring_len == 6'h22)
    else $error("split length is not 34");
endmodule

// ==== tb/dlc_loop_filter_top_tb.sv ====
// Self-checking bench for the loop filter control block.
// Assumes the rtl folder is on the include path; bench drives BASE_TICK itself.
module dlc_loop_filter_top_tb;
  import dlc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic CLOCK = 0, ARST_N = 0, WR = 0, RD = 0, BASE_TICK = 0, STOP_REQ = 0, MONITOR_EVENT = 0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [15:0] RDATA;
  logic INTERNAL_CLOCK_TICK, INTERNAL_STABLE_FLAG, MONITOR_ON, IRQ;
  logic [7:0] STAGE_CODE, TRIM_CODE;
  logic [3:0] DIVIDER_CODE;
  int failures = 0, num_checks = 0;
  int n, per, bcnt = 0, tcnt = 0, exp_code = 0, err, stp;
  bit mon_en = 0, pend = 0, stb = 0;
  logic [15:0] saved;
  localparam int BASE_PER = 272; // CLOCK cycles per base clock period
  // Clock generator, 40 MHz
  always #12.5 CLOCK = ~CLOCK;
  dlc_loop_filter_top dut_u (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .BASE_TICK(BASE_TICK), .STOP_REQ(STOP_REQ),
    .MONITOR_EVENT(MONITOR_EVENT), .INTERNAL_CLOCK_TICK(INTERNAL_CLOCK_TICK),
    .STAGE_CODE(STAGE_CODE), .DIVIDER_CODE(DIVIDER_CODE), .TRIM_CODE(TRIM_CODE),
    .INTERNAL_STABLE_FLAG(INTERNAL_STABLE_FLAG), .MONITOR_ON(MONITOR_ON), .IRQ(IRQ));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    chk("rdata", exp, RDATA);
  endtask
  // Base clock pulses for a number of correction windows
  task automatic run_win(int w);
    repeat (4 * w)
    begin
      @(posedge CLOCK);
      BASE_TICK <= 1'b1;
      @(posedge CLOCK);
      BASE_TICK <= 1'b0;
      repeat (BASE_PER - 2) @(posedge CLOCK);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Filter model: counts ticks per window and predicts each correction
  // ----------------------------------------------------------------
  always @(posedge CLOCK)
  begin
    if (mon_en)
    begin
      if (pend)
      begin
        chk("codes", 16'(exp_code), {4'h0, DIVIDER_CODE, STAGE_CODE});
        chk("stable", 16'(stb), {15'h0, INTERNAL_STABLE_FLAG});
        pend = 0;
      end
      if (BASE_TICK && bcnt == 3)
      begin
        err = tcnt - 4 * n;
        stp = (err * err * 400 > 9 * 16 * n * n) ? 32 : (err * err * 400 < 16 * n * n) ? 1 : 8;
        if (stp == 1)
          stb = 1;
        if (err > 0)
          exp_code = (exp_code + stp > 4095) ? 4095 : exp_code + stp;
        else if (err < 0)
          exp_code = (exp_code - stp < 0) ? 0 : exp_code - stp;
        bcnt = 0;
        tcnt = INTERNAL_CLOCK_TICK;
        pend = 1;
      end
      else
      begin
        bcnt += BASE_TICK;
        tcnt += INTERNAL_CLOCK_TICK;
      end
    end
  end
  // Watchdog against a hung run
  initial
  begin
    #(25 * 80000);
    failures++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h2d244644));
    n = 6 + $urandom % 3;
    repeat (16) @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    // Reset contents of every index, one unmapped
    rd(4'h0, 16'h0001);
    rd(4'h1, 16'h0001);
    rd(4'h2, 16'h0080);
    rd(4'h3, 16'h0004);
    rd(4'h4, 16'h0000);
    rd(4'h5, 16'h0000);
    rd(4'h6, 16'h0000);
    wr(4'h7, 16'($urandom));
    rd(4'h7, 16'h0000);
    chk("trim", 16'h0080, {8'h0, TRIM_CODE});
    // Ring length at code zero: tick every 17 cycles
    per = 0;
    while (INTERNAL_CLOCK_TICK !== 1'b1 && per < 100) begin @(posedge CLOCK); #1 per++; end
    per = 0;
    do begin @(posedge CLOCK); #1 per++; end while (INTERNAL_CLOCK_TICK !== 1'b1 && per < 100);
    chk("ring_period", 16'd17, 16'(per));
    // Monitor enable refused while unstable, interrupt raised, masked, cleared
    wr(4'h0, 16'h0003);
    chk("mon_refused", 16'h0000, {15'h0, MONITOR_ON});
    rd(4'h5, 16'h0004);
    chk("irq_masked", 16'h0000, {15'h0, IRQ});
    wr(4'h6, 16'h0004);
    chk("irq_on", 16'h0001, {15'h0, IRQ});
    wr(4'h5, 16'h0004);
    chk("irq_clr", 16'h0000, {15'h0, IRQ});
    @(posedge CLOCK);
    MONITOR_EVENT <= 1'b1;
    @(posedge CLOCK);
    MONITOR_EVENT <= 1'b0;
    rd(4'h5, 16'h0002);
    wr(4'h5, 16'h0002);
    // Settling from the fastest code toward the multiplier target
    wr(4'h1, 16'(n));
    mon_en = 1;
    for (int w = 0; w < 45 && !stb; w++) run_win(1);
    repeat (3) @(posedge CLOCK);
    chk("settled", 16'h0001, 16'(stb));
    rd(4'h5, 16'h0001);
    wr(4'h6, 16'h0001);
    chk("irq_stable", 16'h0001, {15'h0, IRQ});
    wr(4'h0, 16'h0003);
    chk("mon_on", 16'h0001, {15'h0, MONITOR_ON});
    // Frequency change flow: event flag clear, monitor off, then multiplier
    rd(4'h5, 16'h0001);
    wr(4'h0, 16'h0001);
    chk("mon_off", 16'h0000, {15'h0, MONITOR_ON});
    wr(4'h1, 16'(n));
    @(posedge CLOCK);
    #1 chk("same_mult", 16'h0001, {15'h0, INTERNAL_STABLE_FLAG});
    mon_en = 0;
    wr(4'h1, 16'(n + 1));
    @(posedge CLOCK);
    #1 chk("new_mult", 16'h0000, {15'h0, INTERNAL_STABLE_FLAG});
    // Monitor stays off until the new multiplier has settled
    wr(4'h0, 16'h0003);
    chk("mon_again", 16'h0000, {15'h0, MONITOR_ON});
    // Stop mode freezes the codes
    saved = {4'h0, DIVIDER_CODE, STAGE_CODE};
    @(posedge CLOCK);
    STOP_REQ <= 1'b1;
    run_win(2);
    chk("frozen", saved, {4'h0, DIVIDER_CODE, STAGE_CODE});
    STOP_REQ <= 1'b0;
    repeat (4) @(posedge CLOCK);
    finish_test();
  end
endmodule
